//--- hdl/vic_pkg.sv
package vic_pkg;

    // Register indices and their byte addresses on the bus (four bytes per index).
    localparam logic [7:0] PRIMARY_IDX = 8'h0B;
    localparam logic [7:0] SECONDARY_IDX = 8'h1E;
    localparam logic [7:0] PRIMARY_ADDR = {PRIMARY_IDX[5:0], 2'b00};
    localparam logic [7:0] SECONDARY_ADDR = {SECONDARY_IDX[5:0], 2'b00};

    // Field positions in the primary control register.
    localparam int unsigned P_GLOBAL_EN = 0;
    localparam int unsigned P_EXT_EN = 1;
    localparam int unsigned P_TIMER_EN = 2;
    localparam int unsigned P_CONV_EN = 3;
    localparam int unsigned P_EXT_FLAG = 4;
    localparam int unsigned P_TIMER_FLAG = 5;
    localparam int unsigned P_CONV_FLAG = 6;
    localparam int unsigned P_TEST = 7;

    // Field positions in the secondary control register.
    localparam int unsigned S_TWOWIRE_EN = 0;
    localparam int unsigned S_SERIAL_EN = 1;
    localparam int unsigned S_TWOWIRE_FLAG = 4;
    localparam int unsigned S_SERIAL_FLAG = 5;

    // Source numbering, which is also the priority order, highest first.
    localparam int unsigned SRC_EXT = 0;
    localparam int unsigned SRC_TIMER = 1;
    localparam int unsigned SRC_CONV = 2;
    localparam int unsigned SRC_TWOWIRE = 3;
    localparam int unsigned SRC_SERIAL = 4;
    localparam int unsigned NUM_SRC = 5;

    // Service vector of each source, indexed by source number.
    localparam logic [7:0] VECTORS [NUM_SRC] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};

    // Values after reset.
    localparam logic [7:0] PRIMARY_RST = 8'h00;
    localparam logic [7:0] SECONDARY_RST = 8'h00;
    localparam logic EXT_PIN_RST = 1'b1;

    // Event inputs from the peripherals and the external pin.
    typedef struct packed {
        logic ext_n;
        logic timer_ovf;
        logic conv_done;
        logic slave_addr_match;
        logic twowire_byte_done;
        logic serial_tx_done;
        logic serial_rx_done;
        logic serial_addr_det;
    } vic_src_t;

    // Status and strobes from the processor sequencer.
    typedef struct packed {
        logic fetch_phase_pulse;
        logic stack_full;
        logic return_with_enable;
        logic plain_return;
        logic halt_exec;
        logic halted;
    } vic_core_t;

    // Call request handed to the sequencer.
    typedef struct packed {
        logic call;
        logic [7:0] vector;
    } vic_call_t;

endpackage

//--- hdl/vic_irq_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Falling edge on external pin sets its flag.
// - External request calls 04H, clears flag, global enable.
// - Timer overflow flag; service calls 08H, clears both.
// - Conversion done flag; service calls 0CH, clears both.
// - Address match or byte done; service calls 10H.
// - Serial done or address; service calls 14H.
// - Entry pushes only the program counter.
// - No acknowledge while the stack is full.
// - Flags still latch while global enable is clear.
// - Re-enabling inside a handler allows nesting.
// - Return-with-enable sets global enable; plain return not.
// - Requests are serviced at the next fetch pulse.
// - Fixed priority: external, timer, converter, two-wire, serial.
// - Clear global enable masks every source.
// - Flags hold until serviced or cleared by software.
// - Primary register holds the four enable bits.
// - Secondary register layout; unused bits read zero.
// - Every source can wake the halted device.
// - Flag already set at halt disables its wake-up.
module vic_irq_ctrl (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Register bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt sources.
    input wire vic_pkg::vic_src_t sources,
    // Processor sequencer.
    input wire vic_pkg::vic_core_t core,
    output vic_pkg::vic_call_t irq_call,
    output logic push_pc,
    output logic wake_req
);

    logic ext_pin_ff;
    logic global_en_ff;
    logic test_bit_ff;
    logic [vic_pkg::NUM_SRC-1:0] src_en_ff;
    logic [vic_pkg::NUM_SRC-1:0] flags_ff;
    logic [vic_pkg::NUM_SRC-1:0] wake_block_ff;
    logic [31:0] prdata_ff;
    vic_pkg::vic_call_t call_ff;
    logic wake_req_ff;

    logic [vic_pkg::NUM_SRC-1:0] hw_set;
    logic [vic_pkg::NUM_SRC-1:0] pending;
    logic [vic_pkg::NUM_SRC-1:0] nxt_flags;
    logic [vic_pkg::NUM_SRC-1:0] nxt_src_en;
    logic [vic_pkg::NUM_SRC-1:0] new_wake;
    logic [2:0] grant_idx;
    logic take;
    logic nxt_global_en;
    logic nxt_test_bit;
    logic wr_pri;
    logic wr_sec;
    logic hit;
    logic [7:0] rd_byte;

    // Bus decode: zero-wait slave, error on any unmapped address.
    assign hit = (paddr == vic_pkg::PRIMARY_ADDR) || (paddr == vic_pkg::SECONDARY_ADDR);
    assign wr_pri = psel && penable && pwrite && (paddr == vic_pkg::PRIMARY_ADDR);
    assign wr_sec = psel && penable && pwrite && (paddr == vic_pkg::SECONDARY_ADDR);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_ff;

    // External pin history for falling-edge detection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_pin_ff <= vic_pkg::EXT_PIN_RST;
        end else begin
            ext_pin_ff <= sources.ext_n;
        end
    end

    // Hardware events that set each request flag.
    always_comb begin
        hw_set = '0;
        hw_set[vic_pkg::SRC_EXT] = ext_pin_ff && !sources.ext_n;
        hw_set[vic_pkg::SRC_TIMER] = sources.timer_ovf;
        hw_set[vic_pkg::SRC_CONV] = sources.conv_done;
        hw_set[vic_pkg::SRC_TWOWIRE] = sources.slave_addr_match
            || sources.twowire_byte_done;
        hw_set[vic_pkg::SRC_SERIAL] = sources.serial_tx_done || sources.serial_rx_done
            || sources.serial_addr_det;
    end

    // Fixed priority pick among enabled pending sources, lowest number first.
    always_comb begin
        pending = flags_ff & src_en_ff;
        grant_idx = 3'(vic_pkg::NUM_SRC - 1);
        for (int i = vic_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
                grant_idx = 3'(i);
            end
        end
    end

    // Service happens only at a fetch pulse, with global enable and stack room.
    assign take = core.fetch_phase_pulse && global_en_ff && (|pending)
        && !core.stack_full;

    // Next flag values: software write, then service clear, then hardware set wins.
    always_comb begin
        nxt_flags = flags_ff;
        if (wr_pri) begin
            nxt_flags[vic_pkg::SRC_EXT] = pwdata[vic_pkg::P_EXT_FLAG];
            nxt_flags[vic_pkg::SRC_TIMER] = pwdata[vic_pkg::P_TIMER_FLAG];
            nxt_flags[vic_pkg::SRC_CONV] = pwdata[vic_pkg::P_CONV_FLAG];
        end
        if (wr_sec) begin
            nxt_flags[vic_pkg::SRC_TWOWIRE] = pwdata[vic_pkg::S_TWOWIRE_FLAG];
            nxt_flags[vic_pkg::SRC_SERIAL] = pwdata[vic_pkg::S_SERIAL_FLAG];
        end
        if (take) begin
            nxt_flags[grant_idx] = 1'b0;
        end
        nxt_flags = nxt_flags | hw_set;
    end

    // Request flags.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // Next enable values from software writes.
    always_comb begin
        nxt_src_en = src_en_ff;
        nxt_test_bit = test_bit_ff;
        if (wr_pri) begin
            nxt_src_en[vic_pkg::SRC_EXT] = pwdata[vic_pkg::P_EXT_EN];
            nxt_src_en[vic_pkg::SRC_TIMER] = pwdata[vic_pkg::P_TIMER_EN];
            nxt_src_en[vic_pkg::SRC_CONV] = pwdata[vic_pkg::P_CONV_EN];
            nxt_test_bit = pwdata[vic_pkg::P_TEST];
        end
        if (wr_sec) begin
            nxt_src_en[vic_pkg::SRC_TWOWIRE] = pwdata[vic_pkg::S_TWOWIRE_EN];
            nxt_src_en[vic_pkg::SRC_SERIAL] = pwdata[vic_pkg::S_SERIAL_EN];
        end
    end

    // Per-source enables and the stored test bit, which steers nothing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_en_ff <= '0;
            test_bit_ff <= vic_pkg::PRIMARY_RST[vic_pkg::P_TEST];
        end else begin
            src_en_ff <= nxt_src_en;
            test_bit_ff <= nxt_test_bit;
        end
    end

    // Global enable: write, then return-with-enable, then service entry clears it.
    always_comb begin
        nxt_global_en = global_en_ff;
        if (wr_pri) begin
            nxt_global_en = pwdata[vic_pkg::P_GLOBAL_EN];
        end
        if (core.return_with_enable) begin
            nxt_global_en = 1'b1;
        end
        if (take) begin
            nxt_global_en = 1'b0;
        end
    end

    // Global enable register; a plain return leaves it alone.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_en_ff <= vic_pkg::PRIMARY_RST[vic_pkg::P_GLOBAL_EN];
        end else begin
            global_en_ff <= nxt_global_en;
        end
    end

    // Call request to the sequencer: one-cycle pulse with the vector.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            call_ff <= '0;
        end else begin
            call_ff.call <= take;
            if (take) begin
                call_ff.vector <= vic_pkg::VECTORS[grant_idx];
            end
        end
    end

    // Only the program counter is pushed; no other state is saved.
    assign irq_call = call_ff;
    assign push_pc = call_ff.call;

    // Flags already set when halt executes lose their wake-up.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_block_ff <= '0;
        end else if (core.halt_exec) begin
            wake_block_ff <= flags_ff;
        end
    end

    // Any new event from a source not blocked at halt wakes the halted core, enabled or not.
    assign new_wake = hw_set & ~flags_ff & ~wake_block_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_req_ff <= 1'b0;
        end else begin
            wake_req_ff <= core.halted && (|new_wake);
        end
    end

    assign wake_req = wake_req_ff;

    // Read data view of the addressed register.
    always_comb begin
        rd_byte = 8'h00;
        if (paddr == vic_pkg::PRIMARY_ADDR) begin
            rd_byte[vic_pkg::P_GLOBAL_EN] = global_en_ff;
            rd_byte[vic_pkg::P_EXT_EN] = src_en_ff[vic_pkg::SRC_EXT];
            rd_byte[vic_pkg::P_TIMER_EN] = src_en_ff[vic_pkg::SRC_TIMER];
            rd_byte[vic_pkg::P_CONV_EN] = src_en_ff[vic_pkg::SRC_CONV];
            rd_byte[vic_pkg::P_EXT_FLAG] = flags_ff[vic_pkg::SRC_EXT];
            rd_byte[vic_pkg::P_TIMER_FLAG] = flags_ff[vic_pkg::SRC_TIMER];
            rd_byte[vic_pkg::P_CONV_FLAG] = flags_ff[vic_pkg::SRC_CONV];
            rd_byte[vic_pkg::P_TEST] = test_bit_ff;
        end else if (paddr == vic_pkg::SECONDARY_ADDR) begin
            rd_byte[vic_pkg::S_TWOWIRE_EN] = src_en_ff[vic_pkg::SRC_TWOWIRE];
            rd_byte[vic_pkg::S_SERIAL_EN] = src_en_ff[vic_pkg::SRC_SERIAL];
            rd_byte[vic_pkg::S_TWOWIRE_FLAG] = flags_ff[vic_pkg::SRC_TWOWIRE];
            rd_byte[vic_pkg::S_SERIAL_FLAG] = flags_ff[vic_pkg::SRC_SERIAL];
        end
    end

    // Read data is captured in the setup cycle and held through the access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= {24'h000000, rd_byte};
        end
    end

    // Checks on the behaviour above.
    a_ext_edge_flag: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(sources.ext_n) |=> flags_ff[vic_pkg::SRC_EXT])
        else $error("external falling edge did not set its flag");

    a_call_vector: assert property (@(posedge pclk) disable iff (!presetn)
        take |=> irq_call.call && (irq_call.vector == vic_pkg::VECTORS[$past(grant_idx)]))
        else $error("call vector does not match granted source");

    a_ext_first: assert property (@(posedge pclk) disable iff (!presetn)
        take && pending[vic_pkg::SRC_EXT] |=> irq_call.vector == 8'h04 && !global_en_ff)
        else $error("external request not served first at 04H");

    a_entry_clears: assert property (@(posedge pclk) disable iff (!presetn)
        take && !hw_set[grant_idx] |=> !global_en_ff && !flags_ff[$past(grant_idx)])
        else $error("service entry left flag or global enable set");

    a_stack_full: assert property (@(posedge pclk) disable iff (!presetn)
        core.stack_full |=> !irq_call.call)
        else $error("call issued while stack full");

    a_global_mask: assert property (@(posedge pclk) disable iff (!presetn)
        !global_en_ff |=> !irq_call.call)
        else $error("call issued with global enable clear");

    a_fetch_only: assert property (@(posedge pclk) disable iff (!presetn)
        irq_call.call |-> $past(core.fetch_phase_pulse))
        else $error("call not aligned to a fetch pulse");

    a_pending_kept: assert property (@(posedge pclk) disable iff (!presetn)
        !global_en_ff && hw_set[vic_pkg::SRC_TIMER] |=> flags_ff[vic_pkg::SRC_TIMER] [*2])
        else $error("timer request lost while masked");

    a_return_sets: assert property (@(posedge pclk) disable iff (!presetn)
        core.return_with_enable && !take |=> global_en_ff)
        else $error("return with enable did not set global enable");

    a_plain_return: assert property (@(posedge pclk) disable iff (!presetn)
        core.plain_return && !core.return_with_enable && !wr_pri && !take
        |=> global_en_ff == $past(global_en_ff))
        else $error("plain return changed global enable");

    a_sec_zero: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == vic_pkg::SECONDARY_ADDR
        |=> prdata[3:2] == 2'b00 && prdata[31:6] == 26'h0)
        else $error("unused secondary bits read nonzero");

    a_wake_blocked: assert property (@(posedge pclk) disable iff (!presetn)
        core.halted && ((hw_set & ~wake_block_ff) == '0) |=> !wake_req)
        else $error("blocked source woke the core");

    a_timer_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        sources.timer_ovf |=> flags_ff[vic_pkg::SRC_TIMER])
        else $error("timer overflow did not set its flag");

    a_conv_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        sources.conv_done |=> flags_ff[vic_pkg::SRC_CONV])
        else $error("conversion done did not set its flag");

    a_twowire_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        sources.slave_addr_match || sources.twowire_byte_done
        |=> flags_ff[vic_pkg::SRC_TWOWIRE])
        else $error("two-wire event did not set its flag");

    a_serial_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        sources.serial_tx_done || sources.serial_rx_done || sources.serial_addr_det
        |=> flags_ff[vic_pkg::SRC_SERIAL])
        else $error("serial event did not set its flag");

    a_flag_held: assert property (@(posedge pclk) disable iff (!presetn)
        flags_ff[vic_pkg::SRC_TIMER] && !take && !wr_pri |=> flags_ff[vic_pkg::SRC_TIMER])
        else $error("timer flag dropped without service or clear");

    a_wake_event: assert property (@(posedge pclk) disable iff (!presetn)
        core.halted && sources.conv_done && !flags_ff[vic_pkg::SRC_CONV]
        && !wake_block_ff[vic_pkg::SRC_CONV] |=> wake_req)
        else $error("conversion event did not wake the halted core");

    c_nested: cover property (@(posedge pclk) disable iff (!presetn)
        irq_call.call ##[1:50] irq_call.call);

    c_stack_wait: cover property (@(posedge pclk) disable iff (!presetn)
        (core.stack_full && global_en_ff && |pending) ##[1:8] take);

    c_wake: cover property (@(posedge pclk) disable iff (!presetn) wake_req);

    c_ext_served: cover property (@(posedge pclk) disable iff (!presetn)
        irq_call.call && irq_call.vector == vic_pkg::VECTORS[vic_pkg::SRC_EXT]);

    c_serial_served: cover property (@(posedge pclk) disable iff (!presetn)
        irq_call.call && irq_call.vector == vic_pkg::VECTORS[vic_pkg::SRC_SERIAL]);

endmodule

//--- tb/vic_core_model.sv
`timescale 1ns/1ps
// Sequencer stand-in: fetch pulses, a return stack and the return and halt strobes.
module vic_core_model #(
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Pushes from the block and strobes from the bench.
    input wire logic push_pc,
    input wire logic rtn_en_req,
    input wire logic rtn_req,
    input wire logic halt_req,
    input wire logic halted_in,
    // Status and strobes to the block.
    output vic_pkg::vic_core_t core
);
    logic [1:0] phase_ff;
    int depth_ff;

    // One fetch pulse every four cycles, like one instruction cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) phase_ff <= 2'h0;
        else phase_ff <= phase_ff + 2'h1;
    end

    // The stack grows on each push and shrinks on each return in a cycle without a push, never below empty.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            depth_ff <= 0;
        end else if (push_pc) begin
            depth_ff <= depth_ff + 1;
        end else if ((rtn_en_req || rtn_req) && depth_ff > 0) begin
            depth_ff <= depth_ff - 1;
        end
    end

    // The full flag stays up until a return pops an entry.
    assign core = '{fetch_phase_pulse: (phase_ff == 2'h3), stack_full: (depth_ff >= DEPTH),
        return_with_enable: rtn_en_req, plain_return: rtn_req, halt_exec: halt_req,
        halted: halted_in};
endmodule

//--- tb/vectored_irq_controller_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the interrupt controller.
module vectored_irq_controller_bench;
    localparam logic [7:0] PA = vic_pkg::PRIMARY_ADDR;
    localparam logic [7:0] SA = vic_pkg::SECONDARY_ADDR;
    localparam logic [7:0] EP [8] = '{8'h10, 8'h20, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] ES [8] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h10, 8'h20, 8'h20, 8'h20};
    localparam logic [7:0] WAKE_SRC [4] = '{8'h80, 8'h20, 8'h10, 8'h04};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic push_pc, wake_req, rtn_en_req, rtn_req, halt_req, halted_in;
    vic_pkg::vic_src_t src;
    vic_pkg::vic_core_t core;
    vic_pkg::vic_call_t irq_call;
    int n_errors, n_checks, n_cyc, n_wake, w;

    vic_irq_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sources(src), .core(core), .irq_call(irq_call),
        .push_pc(push_pc), .wake_req(wake_req));
    vic_core_model #(.DEPTH(2)) model_u (.pclk(pclk), .presetn(presetn), .push_pc(push_pc),
        .rtn_en_req(rtn_en_req), .rtn_req(rtn_req), .halt_req(halt_req),
        .halted_in(halted_in), .core(core));

    // Clock of 4 ns.
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Wake pulses are counted, and a hung run is cut short.
    always @(posedge pclk) begin
        n_cyc++;
        if (wake_req === 1'b1) n_wake++;
        if (n_cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; software always writes zero to the test bit.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d & 8'h7F};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(what, {24'h0, exp}, rd);
        chk("pslverr", 32'h0, {31'h0, err});
    endtask

    task automatic pulse_core(input logic [2:0] m);
        @(posedge pclk);
        {rtn_en_req, rtn_req, halt_req} <= m;
        @(posedge pclk);
        {rtn_en_req, rtn_req, halt_req} <= 3'h0;
    endtask

    task automatic pulse_src(input logic [7:0] m);
        @(posedge pclk);
        src <= src ^ m;
        @(posedge pclk);
        src <= src ^ m;
    endtask

    task automatic wait_call(input logic [7:0] vec);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 40 && !seen; i++) begin
            @(posedge pclk);
            if (irq_call.call === 1'b1) begin
                seen = 1'b1;
                chk("vector", {24'h0, vec}, {24'h0, irq_call.vector});
                chk("push_pc", 32'h1, {31'h0, push_pc});
            end
        end
        chk("call", 32'h1, {31'h0, seen});
    endtask

    task automatic no_call(input int n);
        int c;
        c = 0;
        repeat (n) begin
            @(posedge pclk);
            if (irq_call.call !== 1'b0) c++;
        end
        chk("calls", 32'h0, 32'(c));
    endtask

    // Reset values, layout of both registers and an unmapped address.
    task automatic t_regs();
        rchk("primary", PA, 8'h00);
        rchk("secondary", SA, 8'h00);
        apb(1'b0, 8'h00, 8'h00);
        chk("pslverr", 32'h1, {31'h0, err});
        chk("unmapped", 32'h0, rd);
        apb(1'b1, SA, 8'hFF);
        rchk("secondary", SA, 8'h33);
        apb(1'b1, SA, 8'h00);
        apb(1'b1, PA, 8'h0F);
        rchk("primary", PA, 8'h0F);
        apb(1'b1, PA, 8'h00);
        $display("test regs done");
    endtask

    // All five requests at once are served in priority order.
    task automatic t_prio();
        apb(1'b1, SA, 8'h33);
        apb(1'b1, PA, 8'h7F);
        for (int i = 0; i < 5; i++) begin
            wait_call(vic_pkg::VECTORS[i]);
            pulse_core(3'b100);
        end
        rchk("primary", PA, 8'h0F);
        rchk("secondary", SA, 8'h03);
        apb(1'b1, PA, 8'h00);
        apb(1'b1, SA, 8'h00);
        $display("test priority done");
    endtask

    // Every event sets its flag while the global enable is clear, and nothing is served.
    task automatic t_events();
        apb(1'b1, PA, 8'h0E);
        apb(1'b1, SA, 8'h03);
        for (int i = 0; i < 8; i++) begin
            pulse_src(8'h80 >> i);
            no_call(8);
            rchk("primary", PA, EP[i] | 8'h0E);
            rchk("secondary", SA, ES[i] | 8'h03);
            apb(1'b1, PA, 8'h0E);
            apb(1'b1, SA, 8'h03);
        end
        apb(1'b1, PA, 8'h00);
        apb(1'b1, SA, 8'h00);
        $display("test events done");
    endtask

    // Nesting until the stack is full, then service resumes after a pop.
    task automatic t_stack();
        apb(1'b1, PA, 8'h25);
        wait_call(8'h08);
        apb(1'b1, PA, 8'h25);
        wait_call(8'h08);
        apb(1'b1, PA, 8'h25);
        no_call(16);
        rchk("primary", PA, 8'h25);
        pulse_core(3'b010);
        wait_call(8'h08);
        pulse_core(3'b010);
        pulse_core(3'b010);
        rchk("primary", PA, 8'h04);
        apb(1'b1, PA, 8'h00);
        $display("test stack done");
    endtask

    // A flag set before halt blocks its own wake-up even once cleared; other sources wake.
    task automatic t_halt();
        apb(1'b1, PA, 8'h20);
        pulse_core(3'b001);
        @(posedge pclk);
        halted_in <= 1'b1;
        apb(1'b1, PA, 8'h00);
        w = n_wake;
        pulse_src(8'h40);
        repeat (4) @(posedge pclk);
        chk("wakes", 32'(w), 32'(n_wake));
        for (int i = 0; i < 4; i++) begin
            pulse_src(WAKE_SRC[i]);
            repeat (4) @(posedge pclk);
            chk("wakes", 32'(w + i + 1), 32'(n_wake));
        end
        @(posedge pclk);
        halted_in <= 1'b0;
        apb(1'b1, PA, 8'h00);
        apb(1'b1, SA, 8'h00);
        $display("test halt done");
    endtask

    // Reset for eight cycles, then the scenarios in turn.
    initial begin
        {presetn, psel, penable, pwrite, rtn_en_req, rtn_req, halt_req, halted_in} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        src = 8'h80;
        n_errors = 0;
        n_checks = 0;
        n_cyc = 0;
        n_wake = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_prio();
        t_events();
        t_stack();
        t_halt();
        end_sim();
    end
endmodule
